// >>> rtl/tbc_defs.svh
// constants for the timer time base: encodings, resets and timing counts
`ifndef TBC_DEFS_SVH
`define TBC_DEFS_SVH

`define TBC_CNT_W          16
`define TBC_ARR_RESET      16'hffff
`define TBC_PSC_RESET      4'h0
`define TBC_SMS_INTERNAL   3'h0
`define TBC_SMS_EXTCLK1    3'h7
`define TBC_TS_CH2         3'h6
`define TBC_ETRSEL_PCLK    2'h0
`define TBC_ETRSEL_OSC1K   2'h1
`define TBC_ETRSEL_OSC32K  2'h2
`define TBC_ETRSEL_PIN     2'h3
`define TBC_SYNC_STAGES    2
`define TBC_FILT_W         4

`endif

// >>> rtl/tbc_pkg.sv
// types shared by the timer time base
`default_nettype none
package tbc_pkg;

  typedef enum logic [0:0] {
    TBC_EDGE_ALIGNED   = 1'b0,
    TBC_CENTER_ALIGNED = 1'b1
  } tbc_align_t;

  typedef enum logic [0:0] {
    TBC_DIR_UP   = 1'b0,
    TBC_DIR_DOWN = 1'b1
  } tbc_dir_t;

endpackage
`default_nettype wire

// >>> rtl/tbc_input_cond.sv
// input conditioner: two-flop sync, digital filter, polarity, edge pulse
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defs.svh"
module tbc_input_cond #(
  parameter int FILT_W = `TBC_FILT_W
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              asyncIn,
  input  wire logic [FILT_W-1:0] filterLen,
  input  wire logic              invert,
  output logic                   edgePulse
);
  logic              sync1_reg;
  logic              sync2_reg;
  logic              filt_reg;
  logic              filtPrev_reg;
  logic [FILT_W-1:0] run_reg;
  logic [FILT_W-1:0] run_next;
  logic              accept;

  // run counts consecutive samples that differ from the filtered level
  assign accept   = (sync2_reg != filt_reg) && (run_reg >= filterLen);
  assign run_next = (sync2_reg == filt_reg || accept) ? '0
                  : run_reg + {{(FILT_W-1){1'b0}}, 1'b1};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg    <= 1'b0;
      sync2_reg    <= 1'b0;
      filt_reg     <= 1'b0;
      filtPrev_reg <= 1'b0;
      run_reg      <= '0;
      edgePulse    <= 1'b0;
    end else begin
      sync1_reg    <= asyncIn;
      sync2_reg    <= sync1_reg;
      run_reg      <= run_next;
      filt_reg     <= accept ? sync2_reg : filt_reg;
      filtPrev_reg <= filt_reg;
      edgePulse    <= (filt_reg ^ invert) & ~(filtPrev_reg ^ invert);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/tbc_time_base.sv
// timer time base: counter, prescaler, auto-reload, update and clock select
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defs.svh"
// Behaviour
// - up mode counts 0 to auto-reload, wraps to 0, flags overflow
// - update on overflow, software update-generate, or slave request
// - update-disable blocks all updates; shadows hold until cleared
// - up mode software update restarts counter and prescaler at 0
// - request-source set: software update reloads but raises no flag
// - each update: flag (except quiet request-source ones), prescaler shadow and auto-reload shadow load
// - down mode counts auto-reload to 0, reloads, flags underflow
// - down mode software update reloads auto-reload, prescaler to 0
// - down mode auto-reload transfers before counter reload
// - center mode: up to reload-1 overflow, down to 1 underflow
// - center mode direction is hardware-owned, software ignored
// - center mode updates at both ends; forced update restarts at 0
// - center mode, updates off: keeps counting with active reload
// - center overflow: reload refreshed first, counter takes new value
// - slave mode 000: internal clock once enabled; generate acts each cycle it is held
// - slave mode 111 counts channel 2 filtered edges, trigger sel 110
// - each valid mode 1 edge clocks the prescaler and sets trigger flag
// - capture prescaler never divides the trigger path
// - mode 2 enable counts selected edges of external trigger
// - trigger source: clock, 1 kHz, 32 kHz, external clock pin
// - source 11 with mask enable ANDs clock pin with mask pin
// - trigger prescale, polarity 0 rising, filter 0000 none
// - prescaler divides by two to the 4-bit exponent
// - auto-reload buffer reaches active immediately or on update
// - internal count enable follows enable bit one cycle later
module tbc_time_base
  import tbc_pkg::*;
#(
  parameter int CNT_W = `TBC_CNT_W,
  parameter int EXP_W = 4
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             counterEnableBit,
  input  wire logic             countDirectionBit,
  input  wire tbc_align_t       alignMode,
  input  wire logic             updateGenerateBit,
  input  wire logic             slaveUpdateRequest,
  input  wire logic             updateDisableBit,
  input  wire logic             updateRequestSourceBit,
  input  wire logic             autoreloadBufferEnable,
  input  wire logic [CNT_W-1:0] autoreloadValue,
  input  wire logic [EXP_W-1:0] prescaleExponent,
  input  wire logic [2:0]       slaveModeSelect,
  input  wire logic [2:0]       triggerSelect,
  input  wire logic [3:0]       channel2InputFilter,
  input  wire logic             channel2Polarity,
  input  wire logic             externalClockMode2Enable,
  input  wire logic [1:0]       extTriggerSourceSelect,
  input  wire logic             clockMaskEnable,
  input  wire logic [3:0]       extTriggerFilter,
  input  wire logic [1:0]       extTriggerPrescaler,
  input  wire logic             extTriggerPolarity,
  input  wire logic             channel2Input,
  input  wire logic             externalClockPin,
  input  wire logic             clockMaskPin,
  input  wire logic             osc1kHz,
  input  wire logic             osc32kHz,
  output logic [CNT_W-1:0]      count,
  output tbc_dir_t              countDirection,
  output logic [CNT_W-1:0]      activeAutoreload,
  output logic [EXP_W-1:0]      activePrescaleExponent,
  output logic                  internalCountEnable,
  output logic                  updateEvent,
  output logic                  updateInterruptFlag,
  output logic                  triggerInterruptFlag,
  output logic                  overflowPulse,
  output logic                  underflowPulse
);

  // ---------------- clock selection ----------------
  logic       ch2Edge;
  logic       etrEdge;
  logic       etrRaw;
  logic       etrGated;
  logic [2:0] etrDiv_reg;
  logic [2:0] etrDiv_next;
  logic [2:0] etrDivTop;
  logic       etrTick;
  logic       extClk1Sel;
  logic       sourceTick;
  logic [3:0] pinSync1_reg;
  logic [3:0] pinSync2_reg;
  logic       clkPinSync;
  logic       maskPinSync;
  logic       osc1kSync;
  logic       osc32kSync;

  // every pin sampled twice before any gate or mux looks at it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinSync1_reg <= 4'h0;
      pinSync2_reg <= 4'h0;
    end else begin
      pinSync1_reg <= {osc32kHz, osc1kHz,
                       clockMaskPin, externalClockPin};
      pinSync2_reg <= pinSync1_reg;
    end
  end

  assign clkPinSync  = pinSync2_reg[0];
  assign maskPinSync = pinSync2_reg[1];
  assign osc1kSync   = pinSync2_reg[2];
  assign osc32kSync  = pinSync2_reg[3];

  // gate after sync, so no glitch from two skewed pins reaches the filter;
  // the conditioner syncs again, costing two cycles of edge latency
  assign etrGated = clkPinSync & (maskPinSync | ~clockMaskEnable);

  always_comb begin
    case (extTriggerSourceSelect)
      `TBC_ETRSEL_OSC1K:  etrRaw = osc1kSync;
      `TBC_ETRSEL_OSC32K: etrRaw = osc32kSync;
      `TBC_ETRSEL_PIN:    etrRaw = etrGated;
      default:            etrRaw = 1'b0;
    endcase
  end

  tbc_input_cond #(
    .FILT_W (4)
  ) u_etr_cond (
    .clk       (clk),
    .resetn    (resetn),
    .asyncIn   (etrRaw),
    .filterLen (extTriggerFilter),
    .invert    (extTriggerPolarity),
    .edgePulse (etrEdge)
  );

  // channel 2 edges go straight to the trigger, no capture divider
  tbc_input_cond #(
    .FILT_W (4)
  ) u_ch2_cond (
    .clk       (clk),
    .resetn    (resetn),
    .asyncIn   (channel2Input),
    .filterLen (channel2InputFilter),
    .invert    (channel2Polarity),
    .edgePulse (ch2Edge)
  );

  // peripheral clock as trigger source: every cycle is an edge
  logic etrSrcEdge;
  assign etrSrcEdge = (extTriggerSourceSelect == `TBC_ETRSEL_PCLK) ? 1'b1
                    : etrEdge;

  // trigger prescale divides by 1, 2, 4 or 8 edges
  assign etrDivTop   = 3'((4'h1 << extTriggerPrescaler) - 4'h1);
  assign etrTick     = etrSrcEdge && (etrDiv_reg >= etrDivTop);
  assign etrDiv_next = !etrSrcEdge ? etrDiv_reg
                     : (etrTick ? 3'h0 : etrDiv_reg + 3'h1);

  assign extClk1Sel = (slaveModeSelect == `TBC_SMS_EXTCLK1)
                   && (triggerSelect == `TBC_TS_CH2);

  // mode 2 takes precedence over mode 1 when both are set
  assign sourceTick = externalClockMode2Enable ? etrTick
                    : extClk1Sel ? ch2Edge
                    : (slaveModeSelect == `TBC_SMS_INTERNAL);

  // ---------------- prescaler ----------------
  logic [CNT_W-1:0] pscCnt_reg;
  logic [CNT_W-1:0] pscTop;
  logic             counterTick;

  assign pscTop = CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1}
                  << activePrescaleExponent) - 1'b1);
  assign counterTick = internalCountEnable && sourceTick
                    && (pscCnt_reg >= pscTop);

  // ---------------- update generation ----------------
  logic forcedUpdate;
  logic overflow;
  logic underflow;
  logic update_event;
  logic isCenter;
  logic goingUp;

  assign isCenter = (alignMode == TBC_CENTER_ALIGNED);
  assign goingUp  = isCenter ? (countDirection == TBC_DIR_UP)
                  : (countDirectionBit == 1'b0);
  assign forcedUpdate = updateGenerateBit | slaveUpdateRequest;

  assign overflow  = counterTick && goingUp
                  && (isCenter ? (count + 1'b1 >= activeAutoreload)
                               : (count >= activeAutoreload));
  assign underflow = counterTick && !goingUp
                  && (isCenter ? (count <= {{(CNT_W-1){1'b0}}, 1'b1})
                               : (count == '0));

  // no update at all while disabled
  assign update_event = !updateDisableBit
            && (overflow || underflow || forcedUpdate);

  // ---------------- auto-reload shadow ----------------
  logic [CNT_W-1:0] arrNext;

  // value the counter reloads with: buffer already transferred on update
  assign arrNext = (!autoreloadBufferEnable || update_event) ? autoreloadValue
                 : activeAutoreload;

  // ---------------- counter next state ----------------
  logic [CNT_W-1:0] count_next;
  tbc_dir_t         dir_next;

  always_comb begin
    count_next = count;
    dir_next   = isCenter ? countDirection
               : (countDirectionBit ? TBC_DIR_DOWN : TBC_DIR_UP);
    // restart even with updates off; only the event is held back
    if (forcedUpdate) begin
      if (!isCenter && countDirectionBit) begin
        count_next = arrNext;
      end else begin
        count_next = '0;
      end
      if (isCenter) begin
        dir_next = TBC_DIR_UP;
      end
    end else if (counterTick) begin
      if (isCenter) begin
        if (overflow) begin
          count_next = arrNext;
          dir_next   = TBC_DIR_DOWN;
        end else if (underflow) begin
          count_next = '0;
          dir_next   = TBC_DIR_UP;
        end else if (goingUp) begin
          count_next = count + 1'b1;
        end else begin
          count_next = count - 1'b1;
        end
      end else if (goingUp) begin
        count_next = overflow ? '0 : count + 1'b1;
      end else begin
        count_next = underflow ? arrNext : count - 1'b1;
      end
    end
  end

  logic [CNT_W-1:0] pscCnt_next;

  // a forced update restarts the prescaler; with updates enabled it also loads the new ratio
  assign pscCnt_next = forcedUpdate ? '0
                     : !(internalCountEnable && sourceTick) ? pscCnt_reg
                     : counterTick ? '0 : pscCnt_reg + 1'b1;

  logic uifSuppress;

  // only a forced update is silenced by request source
  assign uifSuppress = updateRequestSourceBit && forcedUpdate
                    && !(overflow || underflow);

  // ---------------- registers ----------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      etrDiv_reg <= 3'h0;
      pscCnt_reg <= '0;
    end else begin
      etrDiv_reg <= etrDiv_next;
      pscCnt_reg <= pscCnt_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count                  <= '0;
      countDirection         <= TBC_DIR_UP;
      internalCountEnable    <= 1'b0;
    end else begin
      count                  <= count_next;
      countDirection         <= dir_next;
      internalCountEnable    <= counterEnableBit;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      activeAutoreload       <= `TBC_ARR_RESET;
      activePrescaleExponent <= `TBC_PSC_RESET;
    end else begin
      activeAutoreload       <= arrNext;
      if (update_event) begin
        activePrescaleExponent <= prescaleExponent;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      updateEvent          <= 1'b0;
      updateInterruptFlag  <= 1'b0;
      triggerInterruptFlag <= 1'b0;
      overflowPulse        <= 1'b0;
      underflowPulse       <= 1'b0;
    end else begin
      updateEvent          <= update_event;
      updateInterruptFlag  <= update_event && !uifSuppress;
      // trigger flag fires on each valid edge even with counter stopped
      triggerInterruptFlag <= extClk1Sel && !externalClockMode2Enable
                           && ch2Edge;
      overflowPulse        <= overflow;
      underflowPulse       <= underflow;
    end
  end

endmodule
`default_nettype wire

// >>> sim/tbc_time_base_monitor.sv
// concurrent checks on the timer time base ports
`timescale 1ns/1ps
`default_nettype none
module tbc_time_base_monitor
  import tbc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int EXP_W = 4
) (
  input wire logic             clk,
  input wire logic             resetn,
  input wire logic             counterEnableBit,
  input wire logic             updateGenerateBit,
  input wire logic             updateDisableBit,
  input wire logic             updateRequestSourceBit,
  input wire logic [EXP_W-1:0] prescaleExponent,
  input wire tbc_align_t       alignMode,
  input wire logic [CNT_W-1:0] count,
  input wire tbc_dir_t         countDirection,
  input wire logic [CNT_W-1:0] activeAutoreload,
  input wire logic [EXP_W-1:0] activePrescaleExponent,
  input wire logic             internalCountEnable,
  input wire logic             updateEvent,
  input wire logic             updateInterruptFlag,
  input wire logic             overflowPulse,
  input wire logic             underflowPulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_UP_WRAP: assert property (
    overflowPulse && alignMode == TBC_EDGE_ALIGNED |-> count == '0)
    else $error("overflow without wrap to zero");
  AST_DN_WRAP: assert property (
    underflowPulse && alignMode == TBC_EDGE_ALIGNED
    |-> count == activeAutoreload) else $error("underflow reload wrong");
  AST_OVF_UPD: assert property (
    (overflowPulse || underflowPulse) && !$past(updateDisableBit)
    |-> updateEvent) else $error("wrap without update");
  AST_UDIS_BLOCK: assert property (
    $past(updateDisableBit) |-> !updateEvent)
    else $error("update while disabled");
  AST_UG_RESTART: assert property (
    $past(updateGenerateBit) && $past(alignMode) == TBC_EDGE_ALIGNED
    && $past(countDirection) == TBC_DIR_UP
    |-> count == '0 && updateEvent != $past(updateDisableBit))
    else $error("software update did not restart");
  AST_URS_QUIET: assert property (
    $past(updateGenerateBit) && $past(updateRequestSourceBit)
    && !overflowPulse && !underflowPulse |-> !updateInterruptFlag)
    else $error("flag raised by quiet update");
  AST_FLAG_SET: assert property (
    updateEvent && !$past(updateRequestSourceBit) |-> updateInterruptFlag)
    else $error("update without flag");
  AST_PSC_LOAD: assert property (
    updateEvent |-> activePrescaleExponent == $past(prescaleExponent))
    else $error("prescaler not loaded on update");
  AST_CEN_DELAY: assert property (
    $rose(counterEnableBit) |=> $rose(internalCountEnable))
    else $error("count enable not one cycle late");
  COV_CENTER: cover property (overflowPulse && alignMode == TBC_CENTER_ALIGNED);
  COV_UDF: cover property (underflowPulse);
  COV_QUIET: cover property (updateEvent && !updateInterruptFlag);
endmodule
bind tbc_time_base tbc_time_base_monitor #(.CNT_W(CNT_W), .EXP_W(EXP_W))
  tbc_time_base_monitor_inst (.clk(clk), .resetn(resetn),
  .counterEnableBit(counterEnableBit), .updateGenerateBit(updateGenerateBit),
  .updateDisableBit(updateDisableBit),
  .updateRequestSourceBit(updateRequestSourceBit),
  .prescaleExponent(prescaleExponent), .alignMode(alignMode), .count(count),
  .countDirection(countDirection), .activeAutoreload(activeAutoreload),
  .activePrescaleExponent(activePrescaleExponent),
  .internalCountEnable(internalCountEnable), .updateEvent(updateEvent),
  .updateInterruptFlag(updateInterruptFlag), .overflowPulse(overflowPulse),
  .underflowPulse(underflowPulse));
`default_nettype wire

// >>> sim/tbc_pin_model.sv
// pin side stand-in: channel 2, clock and mask pins, slow oscillators
`timescale 1ns/1ps
`default_nettype none
module tbc_pin_model (
  input  wire logic clk,
  output logic      channel2Input,
  output logic      externalClockPin,
  output logic      clockMaskPin,
  output logic      osc1kHz,
  output logic      osc32kHz
);
  initial begin
    channel2Input = 0;
    externalClockPin = 0;
    clockMaskPin = 0;
    osc1kHz = 0;
    osc32kHz = 0;
  end
  // rates scaled up to keep the run short; odd delays keep them async
  always #250.7 osc1kHz = ~osc1kHz;
  always #25.3 osc32kHz = ~osc32kHz;
  // levels held well past the two-flop sync and edge detect
  task automatic pulse(input logic pin, input int len);
    @(negedge clk);
    if (pin) externalClockPin = 1;
    else channel2Input = 1;
    repeat (len) @(negedge clk);
    externalClockPin = 0;
    channel2Input = 0;
    repeat (len) @(negedge clk);
  endtask
  task automatic set_mask(input logic v);
    @(negedge clk);
    clockMaskPin = v;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the timer time base
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tbc_pkg::*;
  logic        clk = 0, resetn = 0, cen = 0, dirB = 0, ugB = 0, slvB = 0;
  logic        udis = 0, urs = 0, abe = 1, ece = 0, mskEn = 0, ch2Pol = 0;
  tbc_align_t  align = TBC_EDGE_ALIGNED;
  logic [15:0] arr = 16'hffff, rnd = 16'h0007, count, actArr, cnt0;
  logic [3:0]  pexp = 4'h0, actExp, ch2Filt = 4'h0;
  logic [2:0]  sms = 3'h0, trigSel = 3'h6;
  logic [1:0]  src = 2'h0, etps = 2'h0;
  logic        ch2, ePin, mPin, o1k, o32k, ice, upd, uif, tif, ovf, udf;
  logic        seenU, seenF;
  tbc_dir_t    dir;
  int          mismatches = 0, cmp_count = 0, trig = 0, n;
  always #2.5 clk = ~clk;
  always @(negedge clk) if (tif === 1'b1) trig <= trig + 1;
  tbc_pin_model tbc_pin_model_inst (.clk(clk), .channel2Input(ch2),
    .externalClockPin(ePin), .clockMaskPin(mPin), .osc1kHz(o1k),
    .osc32kHz(o32k));
  tbc_time_base tbc_time_base_inst (.clk(clk), .resetn(resetn),
    .counterEnableBit(cen), .countDirectionBit(dirB), .alignMode(align),
    .updateGenerateBit(ugB), .slaveUpdateRequest(slvB),
    .updateDisableBit(udis), .updateRequestSourceBit(urs),
    .autoreloadBufferEnable(abe), .autoreloadValue(arr),
    .prescaleExponent(pexp), .slaveModeSelect(sms), .triggerSelect(trigSel),
    .channel2InputFilter(ch2Filt), .channel2Polarity(ch2Pol),
    .externalClockMode2Enable(ece), .extTriggerSourceSelect(src),
    .clockMaskEnable(mskEn), .extTriggerFilter(4'h0),
    .extTriggerPrescaler(etps), .extTriggerPolarity(1'b0),
    .channel2Input(ch2), .externalClockPin(ePin), .clockMaskPin(mPin),
    .osc1kHz(o1k), .osc32kHz(o32k), .count(count), .countDirection(dir),
    .activeAutoreload(actArr), .activePrescaleExponent(actExp),
    .internalCountEnable(ice), .updateEvent(upd),
    .updateInterruptFlag(uif), .triggerInterruptFlag(tif),
    .overflowPulse(ovf), .underflowPulse(udf));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] per(input logic [15:0] a, input int e);
    return (a + 16'h1) << e;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // one-cycle request, then a three-cycle look for the answer
  task automatic pulse_upd(input logic slave);
    @(negedge clk);
    if (slave) slvB = 1;
    else ugB = 1;
    @(negedge clk);
    ugB = 0;
    slvB = 0;
    seenU = 0;
    seenF = 0;
    cnt0 = count;
    repeat (3) begin
      seenU |= upd;
      seenF |= uif;
      @(negedge clk);
    end
  endtask
  task automatic wait_ev(input logic sel, output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (((sel ? udf : ovf) !== 1'b1) && cyc < 5000);
    if (cyc >= 5000) begin
      chk(16'h0, 16'h1);
      finish_test;
    end
  endtask
  task automatic finish_test;
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    finish_test;
  end
  initial begin
    tick(8);
    resetn = 1;
    tick(2);
    rnd = lfsr(rnd);
    arr = {13'h0, rnd[2:0]} + 16'h2;
    abe = 0;
    cen = 1;
    wait_ev(0, n);
    chk(count, 16'h0);
    wait_ev(0, n);
    chk(16'(n), per(arr, 0));
    pexp = 4'h2;
    abe = 1;
    pulse_upd(0);
    chk(cnt0, 16'h0);
    chk({12'h0, actExp}, 16'h2);
    wait_ev(0, n);
    wait_ev(0, n);
    chk(16'(n), per(arr, 2));
    urs = 1;
    pulse_upd(0);
    chk({seenU, seenF}, 16'h2);
    urs = 0;
    pulse_upd(1);
    chk({seenU, seenF}, 16'h3);
    udis = 1;
    arr = arr + 16'h1;
    pulse_upd(0);
    chk(seenU, 16'h0);
    chk(cnt0, 16'h0);
    chk(actArr, arr - 16'h1);
    udis = 0;
    pulse_upd(0);
    chk(actArr, arr);
    pexp = 4'h0;
    dirB = 1;
    tick(2);
    pulse_upd(0);
    chk(cnt0, arr);
    wait_ev(1, n);
    chk(count, arr);
    arr = arr + 16'h2;
    wait_ev(1, n);
    chk(count, arr);
    cen = 0;
    tick(4);
    align = TBC_CENTER_ALIGNED;
    arr = 16'h3;
    abe = 0;
    pulse_upd(0);
    cen = 1;
    wait_ev(0, n);
    wait_ev(0, n);
    chk(16'(n), 16'h6);
    chk({15'h0, dir}, 16'h1);
    udis = 1;
    wait_ev(0, n);
    wait_ev(0, n);
    chk(16'(n), 16'h6);
    wait_ev(1, n);
    chk(count, 16'h0);
    chk({15'h0, dir}, 16'h0);
    udis = 0;
    cen = 0;
    tick(4);
    align = TBC_EDGE_ALIGNED;
    dirB = 0;
    arr = 16'hffff;
    sms = 3'h7;
    tick(4);
    cen = 1;
    pulse_upd(0);
    n = trig;
    repeat (3) tbc_pin_model_inst.pulse(0, 6);
    tick(8);
    chk(count, 16'h3);
    chk(16'(trig - n), 16'h3);
    trigSel = 3'h5;
    tbc_pin_model_inst.pulse(0, 6);
    tick(8);
    chk(count, 16'h3);
    trigSel = 3'h6;
    ch2Filt = 4'h7;
    tbc_pin_model_inst.pulse(0, 6);
    tick(8);
    chk(count, 16'h3);
    ch2Filt = 4'h0;
    ch2Pol = 1;
    repeat (2) tbc_pin_model_inst.pulse(0, 6);
    tick(8);
    chk(count, 16'h5);
    ch2Pol = 0;
    sms = 3'h0;
    ece = 1;
    src = 2'h3;
    etps = 2'h1;
    pulse_upd(0);
    repeat (4) tbc_pin_model_inst.pulse(1, 6);
    tick(8);
    chk(count, 16'h2);
    mskEn = 1;
    repeat (2) tbc_pin_model_inst.pulse(1, 6);
    tick(8);
    chk(count, 16'h2);
    tbc_pin_model_inst.set_mask(1);
    repeat (2) tbc_pin_model_inst.pulse(1, 6);
    tick(8);
    chk(count, 16'h3);
    mskEn = 0;
    for (int s = 0; s < 3; s++) begin
      src = 2'(s);
      pulse_upd(0);
      tick(500);
      chk(16'(count != 16'h0), 16'h1);
    end
    finish_test;
  end
endmodule
`default_nettype wire
